// >>> hw/rmx_regs.vh
`ifndef RMX_REGS_VH
`define RMX_REGS_VH
`define RMX_STEPS 8
`define RMX_T_WIDTH 3
`define RMX_STATE_FETCH 2'h0
`define RMX_STATE_EXEC 2'h1
`define RMX_STATE_EXEC2 2'h2
`define RMX_OP_RESERVED 8'h68
`define RMX_OP_ADV_X 8'h60
`define RMX_OP_LD_X 8'hF0
`define RMX_OP_LD_XA 8'h72
`define RMX_OP_LD_IMM 8'hF8
`define RMX_OP_ST_XD 8'h73
`define RMX_OP_OR_X 8'hF1
`define RMX_OP_AND_X 8'hF2
`define RMX_OP_XOR_X 8'hF3
`define RMX_OP_OR_I 8'hF9
`define RMX_OP_AND_I 8'hFA
`define RMX_OP_XOR_I 8'hFB
`define RMX_TY_LOADN 4'h0
`define RMX_TY_INC 4'h1
`define RMX_TY_DEC 4'h2
`define RMX_TY_LDA 4'h4
`define RMX_TY_STR 4'h5
`define RMX_TY_GLO 4'h8
`define RMX_TY_GHI 4'h9
`define RMX_TY_PLO 4'hA
`define RMX_TY_PHI 4'hB
`define RMX_TY_LBR 4'hC
`define RMX_T_ADDR 3'h1
`define RMX_T_DATA 3'h5
`define RMX_T_LAST 3'h7
`endif

// >>> hw/rmx_exec.v
`timescale 1ns/1ps
`default_nettype none
`include "rmx_regs.vh"

module rmx_exec (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire [3:0] pc_sel_i,
  input wire [3:0] idx_sel_i,
  input wire pc_sel_wr_i,
  input wire idx_sel_wr_i,
  input wire [7:0] mem_rdata_i,
  input wire carry_flag_i,
  input wire out_flag_i,
  output reg [15:0] mem_addr_o,
  output reg [7:0] mem_wdata_o,
  output reg mem_rd_o,
  output reg mem_wr_o,
  output reg [1:0] state_o,
  output reg [7:0] accum_o,
  output reg [3:0] type_digit_o,
  output reg [3:0] code_digit_o,
  output reg [3:0] pc_sel_o,
  output reg [3:0] idx_sel_o,
  output reg carry_flag_o,
  output reg out_flag_o,
  output wire cycle_end_o,
  output wire reserved_op_o
);

////////////////////////////////////////////////////////////////////////////////
// Functions

function [15:0] rmx_step;
  input [15:0] val;
  input down;
  begin
    if (down) begin
      rmx_step = val - 16'h0001;
    end else begin
      rmx_step = val + 16'h0001;
    end
  end
endfunction

// Bitwise ops share one operand path; low code bits pick the operation
function [7:0] rmx_logic;
  input [7:0] acc;
  input [7:0] opnd;
  input [1:0] sel;
  begin
    if (sel == 2'h1) begin
      rmx_logic = acc | opnd;
    end else if (sel == 2'h2) begin
      rmx_logic = acc & opnd;
    end else begin
      rmx_logic = acc ^ opnd;
    end
  end
endfunction

// Bitwise codes of one addressing form, indexed or immediate
function rmx_is_bitwise;
  input [7:0] op;
  input imm;
  begin
    if (imm) begin
      rmx_is_bitwise = (op == `RMX_OP_OR_I) || (op == `RMX_OP_AND_I) || (op == `RMX_OP_XOR_I);
    end else begin
      rmx_is_bitwise = (op == `RMX_OP_OR_X) || (op == `RMX_OP_AND_X) || (op == `RMX_OP_XOR_X);
    end
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Storage

reg [15:0] scratch_q [0:15];
reg [`RMX_T_WIDTH-1:0] tick_q;
reg carry_meta_q;
reg out_meta_q;
reg [3:0] ptr_sel;
reg ptr_post;
reg ptr_down;
reg is_load;
reg is_store;
reg is_logic;
reg exec_long;
integer k;

wire [7:0] opcode = {type_digit_o, code_digit_o};
wire [15:0] ptr_val = scratch_q[ptr_sel];

////////////////////////////////////////////////////////////////////////////////
// Tick phases and status outputs

wire is_fetch = (state_o == `RMX_STATE_FETCH);
wire at_addr = (tick_q == `RMX_T_ADDR);
wire at_data = (tick_q == `RMX_T_DATA);
wire at_last = (tick_q == `RMX_T_LAST);
wire exec_data = at_data && (state_o == `RMX_STATE_EXEC);

assign cycle_end_o = at_last;
// Reserved code is executed as a no-op; callers must not present it
assign reserved_op_o = (state_o != `RMX_STATE_FETCH) && (opcode == `RMX_OP_RESERVED);

////////////////////////////////////////////////////////////////////////////////
// Decode of the execute-cycle memory access

always @* begin
  ptr_sel = code_digit_o;
  ptr_post = 1'b0;
  ptr_down = 1'b0;
  is_load = 1'b0;
  is_store = 1'b0;
  is_logic = 1'b0;
  exec_long = (type_digit_o == `RMX_TY_LBR);
  if (state_o == `RMX_STATE_FETCH) begin
    ptr_sel = pc_sel_o;
  end else if (type_digit_o == `RMX_TY_LOADN && code_digit_o != 4'h0) begin
    is_load = 1'b1;
  end else if (type_digit_o == `RMX_TY_LDA) begin
    is_load = 1'b1;
    ptr_post = 1'b1;
  end else if (type_digit_o == `RMX_TY_STR) begin
    is_store = 1'b1;
  end else if (opcode == `RMX_OP_LD_X) begin
    is_load = 1'b1;
    ptr_sel = idx_sel_o;
  end else if (opcode == `RMX_OP_LD_XA) begin
    is_load = 1'b1;
    ptr_sel = idx_sel_o;
    ptr_post = 1'b1;
  end else if (opcode == `RMX_OP_LD_IMM) begin
    is_load = 1'b1;
    ptr_sel = pc_sel_o;
    ptr_post = 1'b1;
  end else if (opcode == `RMX_OP_ST_XD) begin
    is_store = 1'b1;
    ptr_sel = idx_sel_o;
    ptr_post = 1'b1;
    ptr_down = 1'b1;
  end else if (rmx_is_bitwise(opcode, 1'b0)) begin
    is_logic = 1'b1;
    ptr_sel = idx_sel_o;
  end else if (rmx_is_bitwise(opcode, 1'b1)) begin
    is_logic = 1'b1;
    ptr_sel = pc_sel_o;
    ptr_post = 1'b1;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Cycle counter; eight ticks make one machine cycle

always @(posedge mclk_i) begin
  if (sys_rst_i) begin
    tick_q <= {`RMX_T_WIDTH{1'b0}};
  end else begin
    tick_q <= tick_q + {{(`RMX_T_WIDTH-1){1'b0}}, 1'b1};
  end
end

////////////////////////////////////////////////////////////////////////////////
// Fetch and execute sequencing

always @(posedge mclk_i) begin
  if (sys_rst_i) begin
    state_o <= `RMX_STATE_FETCH;
  end else if (at_last) begin
    // Long ops get a second, otherwise idle, execute cycle
    case (state_o)
      `RMX_STATE_FETCH: begin
        state_o <= `RMX_STATE_EXEC;
      end
      `RMX_STATE_EXEC: begin
        if (exec_long) begin
          state_o <= `RMX_STATE_EXEC2;
        end else begin
          state_o <= `RMX_STATE_FETCH;
        end
      end
      default: begin
        state_o <= `RMX_STATE_FETCH;
      end
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// Pointer selectors

// Written any time; a write mid-cycle moves the pointer at once
always @(posedge mclk_i) begin
  if (sys_rst_i) begin
    pc_sel_o <= 4'h0;
    idx_sel_o <= 4'h0;
  end else begin
    if (pc_sel_wr_i) begin
      pc_sel_o <= pc_sel_i;
    end
    if (idx_sel_wr_i) begin
      idx_sel_o <= idx_sel_i;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Flag pins

// Asynchronous pins; two stages before anything reads them
always @(posedge mclk_i) begin
  if (sys_rst_i) begin
    carry_meta_q <= 1'b0;
    carry_flag_o <= 1'b0;
  end else begin
    carry_meta_q <= carry_flag_i;
    carry_flag_o <= carry_meta_q;
  end
end

always @(posedge mclk_i) begin
  if (sys_rst_i) begin
    out_meta_q <= 1'b0;
    out_flag_o <= 1'b0;
  end else begin
    out_meta_q <= out_flag_i;
    out_flag_o <= out_meta_q;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Memory interface

// Address and data launch at tick 1 and stand for the whole cycle
always @(posedge mclk_i) begin
  if (sys_rst_i) begin
    mem_addr_o <= 16'h0000;
    mem_wdata_o <= 8'h00;
    mem_rd_o <= 1'b0;
    mem_wr_o <= 1'b0;
  end else begin
    mem_rd_o <= 1'b0;
    mem_wr_o <= 1'b0;
    if (at_addr) begin
      mem_addr_o <= ptr_val;
      mem_wdata_o <= accum_o;
      mem_rd_o <= is_fetch || is_load || is_logic;
      mem_wr_o <= !is_fetch && is_store;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Instruction digits

// Digits hold through execute; the decode reads them
always @(posedge mclk_i) begin
  if (sys_rst_i) begin
    type_digit_o <= 4'h0;
    code_digit_o <= 4'h0;
  end else if (is_fetch && at_data) begin
    type_digit_o <= mem_rdata_i[7:4];
    code_digit_o <= mem_rdata_i[3:0];
  end
end

////////////////////////////////////////////////////////////////////////////////
// Accumulator

// Reserved and unlisted codes fall through untouched
always @(posedge mclk_i) begin
  if (sys_rst_i) begin
    accum_o <= 8'h00;
  end else if (exec_data) begin
    if (type_digit_o == `RMX_TY_GLO) begin
      accum_o <= scratch_q[code_digit_o][7:0];
    end else if (type_digit_o == `RMX_TY_GHI) begin
      accum_o <= scratch_q[code_digit_o][15:8];
    end else if (is_load) begin
      accum_o <= mem_rdata_i;
    end else if (is_logic) begin
      accum_o <= rmx_logic(accum_o, mem_rdata_i, code_digit_o[1:0]);
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Scratch-pad file

// One write port: each cycle touches at most one register
// Fetch advance and execute writes never share a cycle
always @(posedge mclk_i) begin
  if (sys_rst_i) begin
    for (k = 0; k < 16; k = k + 1) begin
      scratch_q[k] <= 16'h0000;
    end
  end else if (is_fetch && at_data) begin
    scratch_q[pc_sel_o] <= rmx_step(ptr_val, 1'b0);
  end else if (exec_data) begin
    if (type_digit_o == `RMX_TY_INC) begin
      scratch_q[code_digit_o] <= rmx_step(scratch_q[code_digit_o], 1'b0);
    end else if (type_digit_o == `RMX_TY_DEC) begin
      scratch_q[code_digit_o] <= rmx_step(scratch_q[code_digit_o], 1'b1);
    end else if (type_digit_o == `RMX_TY_PLO) begin
      scratch_q[code_digit_o][7:0] <= accum_o;
    end else if (type_digit_o == `RMX_TY_PHI) begin
      scratch_q[code_digit_o][15:8] <= accum_o;
    end else if (opcode == `RMX_OP_ADV_X) begin
      scratch_q[idx_sel_o] <= rmx_step(scratch_q[idx_sel_o], 1'b0);
    end else if (ptr_post) begin
      // Pointer moves at the edge where a load takes its byte; a store wrote its byte three ticks earlier
      scratch_q[ptr_sel] <= rmx_step(ptr_val, ptr_down);
    end
  end
end

endmodule // rmx_exec
`default_nettype wire

// >>> tb/rmx_mem.sv
`timescale 1ns/1ps
`default_nettype none
module rmx_mem (
  input wire logic mclk_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic rd_i,
  input wire logic wr_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:65535];
  logic [2:0] live_q = 3'h0;
  always @(posedge mclk_i) begin
    if (wr_i) mem[addr_i] <= wdata_i;
    live_q <= rd_i ? 3'h5 : live_q - {2'h0, live_q != 3'h0};
  end
  // Outside the read window show the inverse, never stale data
  assign rdata_o = (live_q != 3'h0) ? mem[addr_i] : ~mem[addr_i];
endmodule // rmx_mem
`default_nettype wire

// >>> tb/rmx_exec_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "rmx_regs.vh"
module rmx_exec_chk (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] mem_rdata_i,
  input wire logic carry_flag_i,
  input wire logic out_flag_i,
  input wire logic out_flag_o,
  input wire logic reserved_op_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic [7:0] mem_wdata_o,
  input wire logic mem_rd_o,
  input wire logic mem_wr_o,
  input wire logic [1:0] state_o,
  input wire logic [7:0] accum_o,
  input wire logic [3:0] type_digit_o,
  input wire logic [3:0] code_digit_o,
  input wire logic carry_flag_o,
  input wire logic cycle_end_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  wire fe_end = cycle_end_o && state_o == `RMX_STATE_FETCH;
  sequence mcyc;
    !cycle_end_o [*7] ##1 cycle_end_o;
  endsequence
  cyc_len_a: assert property (cycle_end_o |=> mcyc)
    else $error("machine cycle length");
  rd_slot_a: assert property (mem_rd_o |=> !mem_rd_o ##4 cycle_end_o)
    else $error("read strobe slot");
  fetch_exec_a: assert property (fe_end |-> ##2 state_o == `RMX_STATE_EXEC)
    else $error("fetch not followed by execute");
  digits_a: assert property (fe_end |-> {type_digit_o, code_digit_o} == mem_rdata_i)
    else $error("opcode digits");
  imm_addr_a: assert property (fe_end && {type_digit_o, code_digit_o} == `RMX_OP_LD_IMM
    |-> ##4 mem_addr_o == $past(mem_addr_o, 4) + 16'h1)
    else $error("immediate address");
  store_a: assert property (mem_wr_o |-> mem_wdata_o == accum_o)
    else $error("store data");
  acc_keep_a: assert property (fe_end && type_digit_o inside
    {`RMX_TY_PLO, `RMX_TY_PHI, `RMX_TY_STR} |-> ##8 $past(accum_o, 8) == accum_o)
    else $error("accumulator changed");
  flag_keep_a: assert property (!$past(sys_rst_i) && !$past(sys_rst_i, 2)
    |-> carry_flag_o == $past(carry_flag_i, 2))
    else $error("carry flag altered");
  out_keep_a: assert property (!$past(sys_rst_i) && !$past(sys_rst_i, 2)
    |-> out_flag_o == $past(out_flag_i, 2))
    else $error("output flag altered");
  no_reserved_a: assert property (!reserved_op_o)
    else $error("reserved code presented");
endmodule // rmx_exec_chk
bind rmx_exec rmx_exec_chk u_rmx_exec_chk (.mclk_i, .sys_rst_i, .mem_rdata_i, .carry_flag_i,
  .mem_addr_o, .mem_wdata_o, .mem_rd_o, .mem_wr_o, .state_o, .accum_o, .type_digit_o,
  .code_digit_o, .carry_flag_o, .cycle_end_o, .out_flag_i, .out_flag_o, .reserved_op_o);
`default_nettype wire

// >>> tb/register_memory_instruction_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none
module register_memory_instruction_exec_tb;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] pc_sel_i = 4'h0;
  logic pc_sel_wr_i = 1'b0;
  logic [1:0] flg = 2'h0;
  wire [7:0] mem_rdata_i, mem_wdata_o, accum_o;
  wire [15:0] mem_addr_o;
  wire mem_rd_o, mem_wr_o, cycle_end_o;
  int mc = 0;
  int n_fail = 0;
  int n_compared = 0;
  logic [7:0] prog [0:29] = '{8'hF8, 8'h5A, 8'hA3, 8'hB3, 8'h23, 8'h83, 8'h93, 8'h24, 8'h94,
    8'h14, 8'h84, 8'hF8, 8'hC3, 8'h53, 8'h84, 8'hF8, 8'h00, 8'h43, 8'h03, 8'h60, 8'hF0,
    8'h72, 8'hF0, 8'hF8, 8'h96, 8'h73, 8'hF0, 8'hF8, 8'h40, 8'hB5};
  always #2.5 mclk_i = ~mclk_i;
  always @(negedge mclk_i) flg <= flg + 2'h1;
  always @(posedge mclk_i) if (!sys_rst_i && cycle_end_o === 1'b1) mc <= mc + 1;
  rmx_exec u_rmx_exec (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .pc_sel_i(pc_sel_i),
    .idx_sel_i(4'h3), .pc_sel_wr_i(pc_sel_wr_i), .idx_sel_wr_i(pc_sel_wr_i),
    .mem_rdata_i(mem_rdata_i), .carry_flag_i(flg[0]), .out_flag_i(flg[1]),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_rd_o(mem_rd_o),
    .mem_wr_o(mem_wr_o), .state_o(), .accum_o(accum_o), .type_digit_o(), .code_digit_o(),
    .pc_sel_o(), .idx_sel_o(), .carry_flag_o(), .out_flag_o(), .cycle_end_o(cycle_end_o),
    .reserved_op_o());
  rmx_mem u_rmx_mem (.mclk_i(mclk_i), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
    .rd_i(mem_rd_o), .wr_i(mem_wr_o), .rdata_o(mem_rdata_i));
  ////////////////////////////////////////////////////////////////////////////////
  task end_of_test;
    if (n_fail == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %0t %h %h", $time, got, exp);
    end
  endtask
  // Counts machine cycles from reset, two per instruction, so a slow design cannot hide
  task at(input int n, input logic [7:0] exp);
    for (int k = 0; k < 40 * n && mc < 2 * n; k++) @(negedge mclk_i);
    if (mc < 2 * n) begin
      n_fail++;
      end_of_test;
    end else
      cmp(accum_o, exp);
  endtask
  // Bounded poll for the next accumulator value
  task seek(input logic [7:0] exp);
    for (int k = 0; k < 64 && accum_o !== exp; k++) @(negedge mclk_i);
    cmp(accum_o, exp);
  endtask
  // Writes the selectors only on a machine-cycle boundary
  task set_sel(input logic [3:0] p);
    for (int k = 0; k < 9 && cycle_end_o !== 1'b1; k++) @(negedge mclk_i);
    pc_sel_i = p;
    pc_sel_wr_i = 1'b1;
    @(negedge mclk_i);
    pc_sel_wr_i = 1'b0;
  endtask
  task t_reg;
    at(1, 8'h5A);
    at(5, 8'h59);
    at(6, 8'h5A);
    at(8, 8'hFF);
    at(10, 8'h00);
  endtask
  task t_mem;
    at(12, 8'hC3);
    cmp(u_rmx_mem.mem[16'h5A59], 8'hC3);
    at(13, 8'h00);
    at(15, 8'hC3);
    at(16, 8'hE1);
  endtask
  task t_idx;
    at(18, 8'h2B);
    at(20, 8'hD4);
    at(23, 8'h2B);
    cmp(u_rmx_mem.mem[16'h5A5C], 8'h96);
  endtask
  task t_pc;
    at(25, 8'h40);
    set_sel(4'h5);
    seek(8'h77);
    seek(8'h7F);
    seek(8'h3C);
    seek(8'hC3);
    seek(8'hEB);
    seek(8'h2B);
    seek(8'h00);
  endtask
  initial begin
    for (int i = 0; i < 65536; i++) u_rmx_mem.mem[i] = (i < 30) ? prog[i] : 8'h00;
    u_rmx_mem.mem[16'h4000] = 8'hF8;
    u_rmx_mem.mem[16'h4001] = 8'h77;
    u_rmx_mem.mem[16'h4002] = 8'hF9;
    u_rmx_mem.mem[16'h4003] = 8'h08;
    u_rmx_mem.mem[16'h4004] = 8'hFA;
    u_rmx_mem.mem[16'h4005] = 8'h3C;
    u_rmx_mem.mem[16'h4006] = 8'hFB;
    u_rmx_mem.mem[16'h4007] = 8'hFF;
    u_rmx_mem.mem[16'h4008] = 8'hF1;
    u_rmx_mem.mem[16'h4009] = 8'hF2;
    u_rmx_mem.mem[16'h400A] = 8'hF3;
    u_rmx_mem.mem[16'h5A5A] = 8'hE1;
    u_rmx_mem.mem[16'h5A5B] = 8'h2B;
    u_rmx_mem.mem[16'h5A5C] = 8'hD4;
    repeat (20) @(negedge mclk_i);
    sys_rst_i = 1'b0;
    set_sel(4'h0);
    t_reg;
    t_mem;
    t_idx;
    t_pc;
    end_of_test;
  end
endmodule // register_memory_instruction_exec_tb
`default_nettype wire
